/* shared/smr_consts.svh */
`ifndef SMR_CONSTS_SVH
`define SMR_CONSTS_SVH
// Register byte offsets.
`define SMR_A_MODE    8'h00
`define SMR_A_CMD     8'h04
`define SMR_A_STATE   8'h08
`define SMR_A_PROTO   8'h0C
`define SMR_A_DHAR_HI 8'h10
`define SMR_A_DHAR_LO 8'h14
`define SMR_A_DIPR    8'h18
`define SMR_A_PORT    8'h1C
`define SMR_A_DPORT   8'h20
`define SMR_A_TX_FSR  8'h24
`define SMR_A_TX_WR   8'h28
`define SMR_A_EVENT   8'h2C
`define SMR_A_IDX     8'h30
`define SMR_A_IGMPV   8'h34
// Mode register fields.
`define SMR_MR_MULTI  7
`define SMR_P_CLOSED  4'h0
`define SMR_P_UDP     4'h2
`define SMR_P_RAW_IP_MODE   4'h3
`define SMR_P_RAW_ETHER_MODE  4'h4
// Commands.
`define SMR_CMD_OPEN  8'h01
`define SMR_CMD_CLOSE 8'h10
`define SMR_CMD_SEND  8'h20
// Socket states.
`define SMR_ST_CLOSED 8'h00
`define SMR_ST_UDP    8'h22
`define SMR_ST_RAW_IP_MODE  8'h32
`define SMR_ST_RAW_ETHER_MODE 8'h42
// IP protocol numbers.
`define SMR_PR_ICMP   8'h01
`define SMR_PR_IGMP   8'h02
`define SMR_PR_TCP    8'h06
`define SMR_PR_UDP    8'h11
// Sizes in bytes.
`define SMR_TX_BUF    16'h0800
`define SMR_MIN_FRAME 16'h003C
`define SMR_HDR_RAW_IP_MODE 16'h0006
`define SMR_HDR_UDP   16'h0008
`define SMR_HDR_MAC   16'h0002
// Reset values and event bits.
`define SMR_IGMPV_RST 2'h2
`define SMR_EV_SENDOK 0
`define SMR_EV_TMO    1
// Report period.
`define SMR_REPORT_MS 1000
`define SMR_CLK_MHZ   200
`define SMR_REPORT_CYC (`SMR_REPORT_MS * 1000 * `SMR_CLK_MHZ)
`endif

/* shared/smr_pkg.sv */
package smr_pkg;
    typedef enum logic [1:0] {
        SMR_TX_JOIN   = 2'b00,
        SMR_TX_LEAVE  = 2'b01,
        SMR_TX_REPORT = 2'b10,
        SMR_TX_DATA   = 2'b11
    } smr_tx_kind_t;
    typedef enum logic [1:0] {
        SMR_IDLE  = 2'b00,
        SMR_ISSUE = 2'b01,
        SMR_WAIT  = 2'b10
    } smr_txfsm_t;
    typedef struct packed {
        smr_tx_kind_t kind;
        logic [3:0]   mode;
        logic [1:0]   igmp_ver;
        logic [47:0]  dst_mac;
        logic [31:0]  dst_ip;
        logic [15:0]  src_port;
        logic [15:0]  dst_port;
        logic [7:0]   ip_proto;
        logic [15:0]  start;
        logic [15:0]  len;
        logic [15:0]  pad_len;
    } smr_tx_desc_t;
    typedef struct packed {
        logic [7:0]  proto;
        logic        frag;
        logic [31:0] src_ip;
        logic [15:0] dst_port;
        logic [15:0] len;
    } smr_rx_hdr_t;
    typedef struct packed {
        logic [31:0] src_ip;
        logic [15:0] len;
    } smr_rx_info_t;
endpackage : smr_pkg

/* src/smr_rx_filter.sv */
`timescale 1ns/100ps
`include "smr_consts.svh"
module smr_rx_filter (
    // Clock and reset.
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // Socket configuration.
    input  wire logic [7:0]           state,
    input  wire logic [7:0]           ip_proto,
    input  wire logic [15:0]          src_port,
    input  wire logic [15:0]          rx_free,
    // Inbound packet header.
    input  wire smr_pkg::smr_rx_hdr_t hdr,
    input  wire logic                 hdr_valid,
    // Verdicts.
    output logic                      accept,
    output logic                      drop,
    output logic                      to_hw,
    output smr_pkg::smr_rx_info_t     info
);
    logic        match;
    logic [15:0] hsz;
    logic        ok;

    // Pick the match rule and header size for the socket mode.
    always_comb begin
        match = 1'b0;
        hsz   = `SMR_HDR_UDP;
        case (state)
            `SMR_ST_RAW_IP_MODE: begin
                match = hdr.proto == ip_proto;
                hsz   = `SMR_HDR_RAW_IP_MODE;
            end
            `SMR_ST_UDP: begin
                match = hdr.proto == `SMR_PR_UDP && hdr.dst_port == src_port;
                hsz   = `SMR_HDR_UDP;
            end
            `SMR_ST_RAW_ETHER_MODE: begin
                match = 1'b1;
                hsz   = `SMR_HDR_MAC;
            end
            default: match = 1'b0;
        endcase
        ok = match && (state == `SMR_ST_RAW_ETHER_MODE || !hdr.frag)
            && ({1'b0, hdr.len} + {1'b0, hsz}) <= {1'b0, rx_free};
    end

    // Registered verdicts, one cycle after the header.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            accept <= 1'b0;
            drop   <= 1'b0;
            to_hw  <= 1'b0;
        end else begin
            accept <= hdr_valid && ok;
            drop   <= hdr_valid && !ok;
            to_hw  <= hdr_valid && (hdr.proto == `SMR_PR_ICMP
                || hdr.proto == `SMR_PR_IGMP);
        end
    end

    // six-byte header: sender address and length.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            info <= '0;
        end else if (hdr_valid && ok) begin
            info <= {hdr.src_ip, hdr.len};
        end
    end
endmodule : smr_rx_filter

/* src/smr_socket_top.sv */
// Notes on behaviour
// - Multicast open sends a Join itself.
// - Multicast close sends a Leave itself in version 2 only.
// - Open multicast socket reports periodically when active.
// - Only group protocol versions 1 and 2.
// - Multicast open shows datagram-open state.
// - Multicast send uses configured destination registers.
// - Multicast socket never reports send timeout.
// - Ping and group packets handled in hardware.
// - Raw IP refuses TCP and UDP numbers.
// - Raw IP keeps only configured protocol.
// - Mode 0x03 open gives raw-IP state.
// - Raw IP stores six-byte header then payload.
// - Oversized raw packets dropped, and fragmented raw IP ones.
// - Raw Ethernet only on socket zero.
// - Mode 0x04 open gives raw-Ethernet state.
// - Protocol value 0x02 selects datagram mode.
// - Short raw Ethernet frames padded to 60.
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
`include "smr_consts.svh"
module smr_socket_top #(
    parameter logic [31:0] REPORT_CYCLES = `SMR_REPORT_CYC
) (
    // Clock and reset.
    input  wire logic                  CORE_CLK,
    input  wire logic                  RESETN,
    // Register port.
    input  wire logic [7:0]            REG_ADDR,
    input  wire logic [31:0]           REG_WDATA,
    input  wire logic                  REG_WR,
    input  wire logic                  REG_RD,
    output logic [31:0]                REG_RDATA,
    // Transmit requests to the frame engine.
    output smr_pkg::smr_tx_desc_t      TX_DESC,
    output logic                       TX_VALID,
    input  wire logic                  TX_READY,
    input  wire logic                  TX_DONE,
    input  wire logic                  ARP_TIMEOUT,
    // Receive headers from the frame engine.
    input  wire smr_pkg::smr_rx_hdr_t  RX_HDR,
    input  wire logic                  RX_HDR_VALID,
    input  wire logic [15:0]           RX_FREE,
    output logic                       RX_ACCEPT,
    output logic                       RX_DROP,
    output logic                       RX_TO_HW,
    output smr_pkg::smr_rx_info_t      RX_INFO
);
    logic                 rst_s1_ff, rst_n;
    logic [7:0]           mode_ff, state_ff, proto_ff;
    logic [47:0]          dhar_ff;
    logic [31:0]          dipr_ff, rdata_ff, rpt_cnt_ff;
    logic [15:0]          port_ff, dport_ff, tx_wr_ff, tx_rd_ff;
    logic [1:0]           ev_ff, igmpv_ff;
    logic [2:0]           idx_ff;
    logic                 mcast_ff, join_ff, leave_ff, report_ff;
    logic                 send_ff, traffic_ff;
    smr_pkg::smr_txfsm_t  fsm_ff;
    smr_pkg::smr_tx_desc_t desc_ff;
    logic                 cmd_wr, do_open, do_close, do_send;
    logic                 period_end, data_end, tmo_hit;
    logic [3:0]           psel;
    logic [15:0]          pend_len;

    // Reset release through two flip-flops.
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_s1_ff <= 1'b0;
            rst_n     <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_n     <= rst_s1_ff;
        end
    end

    // Command decode.
    assign cmd_wr   = REG_WR && REG_ADDR == `SMR_A_CMD;
    assign do_open  = cmd_wr && REG_WDATA[7:0] == `SMR_CMD_OPEN
        && state_ff == `SMR_ST_CLOSED;
    assign do_close = cmd_wr && REG_WDATA[7:0] == `SMR_CMD_CLOSE;
    assign do_send  = cmd_wr && REG_WDATA[7:0] == `SMR_CMD_SEND
        && state_ff != `SMR_ST_CLOSED && !send_ff;
    assign psel     = mode_ff[3:0];
    assign pend_len = tx_wr_ff - tx_rd_ff;
    assign data_end = fsm_ff == smr_pkg::SMR_WAIT
        && desc_ff.kind == smr_pkg::SMR_TX_DATA && (TX_DONE || tmo_hit);
    // no address lookup for group or raw Ethernet frames.
    assign tmo_hit  = ARP_TIMEOUT && !mcast_ff
        && state_ff != `SMR_ST_RAW_ETHER_MODE;
    assign period_end = rpt_cnt_ff == REPORT_CYCLES - 32'h1;

    // Pads short raw Ethernet frames to the minimum length.
    function automatic logic [15:0] pad_len(input logic [3:0] p,
                                             input logic [15:0] n);
        pad_len = (p == `SMR_P_RAW_ETHER_MODE && n < `SMR_MIN_FRAME)
            ? `SMR_MIN_FRAME : n;
    endfunction : pad_len

    // Builds a transmit descriptor from the socket registers.
    function automatic smr_pkg::smr_tx_desc_t mk_desc(
        input smr_pkg::smr_tx_kind_t k, input logic [15:0] n);
        mk_desc.kind     = k;
        mk_desc.mode     = mode_ff[3:0];
        mk_desc.igmp_ver = igmpv_ff;
        mk_desc.dst_mac  = dhar_ff;
        mk_desc.dst_ip   = dipr_ff;
        mk_desc.src_port = port_ff;
        mk_desc.dst_port = dport_ff;
        mk_desc.ip_proto = proto_ff;
        mk_desc.start    = tx_rd_ff;
        mk_desc.len      = n;
        mk_desc.pad_len  = pad_len(mode_ff[3:0], n);
    endfunction : mk_desc

    // Configuration registers written by software.
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            mode_ff  <= 8'h00;
            proto_ff <= 8'h00;
            dhar_ff  <= 48'h0;
            dipr_ff  <= 32'h0;
            port_ff  <= 16'h0;
            dport_ff <= 16'h0;
            tx_wr_ff <= 16'h0;
            idx_ff   <= 3'h0;
            igmpv_ff <= `SMR_IGMPV_RST;
        end else if (REG_WR) begin
            case (REG_ADDR)
                `SMR_A_MODE:    mode_ff <= REG_WDATA[7:0];
                `SMR_A_PROTO:   proto_ff <= REG_WDATA[7:0];
                `SMR_A_DHAR_HI: dhar_ff[47:32] <= REG_WDATA[15:0];
                `SMR_A_DHAR_LO: dhar_ff[31:0] <= REG_WDATA;
                `SMR_A_DIPR:    dipr_ff <= REG_WDATA;
                `SMR_A_PORT:    port_ff <= REG_WDATA[15:0];
                `SMR_A_DPORT:   dport_ff <= REG_WDATA[15:0];
                `SMR_A_TX_WR:   tx_wr_ff <= REG_WDATA[15:0];
                `SMR_A_IDX:     idx_ff <= REG_WDATA[2:0];
                `SMR_A_IGMPV: begin
                    // only versions 1 and 2 kept.
                    if (REG_WDATA[1:0] == 2'h1 || REG_WDATA[1:0] == 2'h2)
                        igmpv_ff <= REG_WDATA[1:0];
                end
                default: ;
            endcase
        end
    end

    // Socket state on open and close.
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= `SMR_ST_CLOSED;
            mcast_ff <= 1'b0;
        end else if (do_close) begin
            state_ff <= `SMR_ST_CLOSED;
            mcast_ff <= 1'b0;
        end else if (do_open) begin
            case (psel)
                `SMR_P_UDP: begin
                    state_ff <= `SMR_ST_UDP;
                    mcast_ff <= mode_ff[`SMR_MR_MULTI];
                end
                `SMR_P_RAW_IP_MODE: begin
                    if (proto_ff != `SMR_PR_TCP && proto_ff != `SMR_PR_UDP)
                        state_ff <= `SMR_ST_RAW_IP_MODE;
                end
                `SMR_P_RAW_ETHER_MODE: begin
                    if (idx_ff == 3'h0)
                        state_ff <= `SMR_ST_RAW_ETHER_MODE;
                end
                default: state_ff <= `SMR_ST_CLOSED;
            endcase
        end
    end

    // Group membership messages owed to the network.
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            join_ff   <= 1'b0;
            leave_ff  <= 1'b0;
            report_ff <= 1'b0;
        end else begin
            if (do_open && psel == `SMR_P_UDP && mode_ff[`SMR_MR_MULTI])
                join_ff <= 1'b1;
            else if (do_close || (fsm_ff == smr_pkg::SMR_IDLE && !leave_ff))
                join_ff <= 1'b0;
            // leave on multicast close, version 2 only.
            if (do_close && mcast_ff && igmpv_ff == 2'h2)
                leave_ff <= 1'b1;
            else if (fsm_ff == smr_pkg::SMR_IDLE)
                leave_ff <= 1'b0;
            if (period_end && traffic_ff && mcast_ff && !do_close)
                report_ff <= 1'b1;
            else if (do_close || (fsm_ff == smr_pkg::SMR_IDLE
                    && !leave_ff && !join_ff))
                report_ff <= 1'b0;
        end
    end

    // Report period counter and activity tracking.
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            rpt_cnt_ff <= 32'h0;
            traffic_ff <= 1'b0;
        end else if (!mcast_ff) begin
            rpt_cnt_ff <= 32'h0;
            traffic_ff <= 1'b0;
        end else begin
            rpt_cnt_ff <= period_end ? 32'h0 : rpt_cnt_ff + 32'h1;
            traffic_ff <= (traffic_ff && !period_end)
                || (data_end && TX_DONE) || RX_ACCEPT;
        end
    end

    // Transmit sequencer: leave, join, report, then data.
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            fsm_ff  <= smr_pkg::SMR_IDLE;
            desc_ff <= '0;
        end else begin
            case (fsm_ff)
                smr_pkg::SMR_IDLE: begin
                    if (leave_ff || join_ff || report_ff || send_ff)
                        fsm_ff <= smr_pkg::SMR_ISSUE;
                    if (leave_ff)
                        desc_ff <= mk_desc(smr_pkg::SMR_TX_LEAVE, 16'h0);
                    else if (join_ff)
                        desc_ff <= mk_desc(smr_pkg::SMR_TX_JOIN, 16'h0);
                    else if (report_ff)
                        desc_ff <= mk_desc(smr_pkg::SMR_TX_REPORT, 16'h0);
                    else if (send_ff)
                        desc_ff <= mk_desc(smr_pkg::SMR_TX_DATA, pend_len);
                end
                smr_pkg::SMR_ISSUE: begin
                    if (TX_READY)
                        fsm_ff <= smr_pkg::SMR_WAIT;
                end
                smr_pkg::SMR_WAIT: begin
                    if (TX_DONE || data_end)
                        fsm_ff <= smr_pkg::SMR_IDLE;
                end
                default: fsm_ff <= smr_pkg::SMR_IDLE;
            endcase
        end
    end

    // Send request and read pointer.
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            send_ff  <= 1'b0;
            tx_rd_ff <= 16'h0;
        end else begin
            if (do_send)
                send_ff <= 1'b1;
            else if (data_end || do_close)
                send_ff <= 1'b0;
            if (data_end)
                tx_rd_ff <= desc_ff.start + desc_ff.len;
        end
    end

    // Send events: write one to clear, a new event wins.
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ev_ff <= 2'h0;
        end else begin
            ev_ff[`SMR_EV_SENDOK] <= (data_end && TX_DONE)
                || (ev_ff[`SMR_EV_SENDOK] && !(REG_WR
                && REG_ADDR == `SMR_A_EVENT && REG_WDATA[`SMR_EV_SENDOK]));
            // timeout only where an address lookup runs.
            ev_ff[`SMR_EV_TMO] <= (data_end && !TX_DONE)
                || (ev_ff[`SMR_EV_TMO] && !(REG_WR
                && REG_ADDR == `SMR_A_EVENT && REG_WDATA[`SMR_EV_TMO]));
        end
    end

    // Read data, valid in the cycle after the strobe only.
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 32'h0;
        end else if (!REG_RD) begin
            rdata_ff <= 32'h0;
        end else begin
            case (REG_ADDR)
                `SMR_A_MODE:    rdata_ff <= {24'h0, mode_ff};
                `SMR_A_CMD:     rdata_ff <= {24'h0, send_ff
                                    ? `SMR_CMD_SEND : 8'h00};
                `SMR_A_STATE:   rdata_ff <= {24'h0, state_ff};
                `SMR_A_PROTO:   rdata_ff <= {24'h0, proto_ff};
                `SMR_A_DHAR_HI: rdata_ff <= {16'h0, dhar_ff[47:32]};
                `SMR_A_DHAR_LO: rdata_ff <= dhar_ff[31:0];
                `SMR_A_DIPR:    rdata_ff <= dipr_ff;
                `SMR_A_PORT:    rdata_ff <= {16'h0, port_ff};
                `SMR_A_DPORT:   rdata_ff <= {16'h0, dport_ff};
                `SMR_A_TX_FSR:  rdata_ff <= {16'h0, `SMR_TX_BUF - pend_len};
                `SMR_A_TX_WR:   rdata_ff <= {16'h0, tx_wr_ff};
                `SMR_A_EVENT:   rdata_ff <= {30'h0, ev_ff};
                `SMR_A_IDX:     rdata_ff <= {29'h0, idx_ff};
                `SMR_A_IGMPV:   rdata_ff <= {30'h0, igmpv_ff};
                default:        rdata_ff <= 32'h0;
            endcase
        end
    end

    assign REG_RDATA = rdata_ff;
    assign TX_DESC   = desc_ff;
    assign TX_VALID  = fsm_ff == smr_pkg::SMR_ISSUE;

    // Receive classification.
    smr_rx_filter u_filter (
        .clk       (CORE_CLK),
        .rst_n     (rst_n),
        .state     (state_ff),
        .ip_proto  (proto_ff),
        .src_port  (port_ff),
        .rx_free   (RX_FREE),
        .hdr       (RX_HDR),
        .hdr_valid (RX_HDR_VALID),
        .accept    (RX_ACCEPT),
        .drop      (RX_DROP),
        .to_hw     (RX_TO_HW),
        .info      (RX_INFO)
    );

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!rst_n);

    a_join_on_open: assert property (
        do_open && psel == `SMR_P_UDP && mode_ff[`SMR_MR_MULTI]
        |=> join_ff && mcast_ff) else $error("join not queued");
    a_leave_on_close: assert property (
        do_close && mcast_ff && igmpv_ff == 2'h2 |=> leave_ff)
        else $error("leave not queued");
    a_report_period: assert property (
        period_end && traffic_ff && mcast_ff && !do_close |=> report_ff)
        else $error("report not queued");
    a_igmp_ver_legal: assert property (
        igmpv_ff == 2'h1 || igmpv_ff == 2'h2)
        else $error("bad group version");
    a_udp_open_state: assert property (
        do_open && psel == `SMR_P_UDP |=> state_ff == `SMR_ST_UDP)
        else $error("datagram open failed");
    a_mcast_dest: assert property (
        TX_VALID && TX_DESC.kind == smr_pkg::SMR_TX_DATA && mcast_ff
        |-> TX_DESC.dst_ip == dipr_ff && TX_DESC.dst_port == dport_ff)
        else $error("multicast destination wrong");
    a_no_mcast_tmo: assert property (
        fsm_ff == smr_pkg::SMR_WAIT && mcast_ff && ARP_TIMEOUT && !TX_DONE
        |=> !$rose(ev_ff[`SMR_EV_TMO])) else $error("multicast timeout");
    a_rawip_refuse: assert property (
        do_open && psel == `SMR_P_RAW_IP_MODE && (proto_ff == `SMR_PR_TCP
        || proto_ff == `SMR_PR_UDP) |=> state_ff == `SMR_ST_CLOSED)
        else $error("raw IP took TCP or UDP");
    a_rawip_open: assert property (
        do_open && psel == `SMR_P_RAW_IP_MODE && proto_ff != `SMR_PR_TCP
        && proto_ff != `SMR_PR_UDP |=> state_ff == `SMR_ST_RAW_IP_MODE)
        else $error("raw IP open failed");
    a_raw_ether_mode_sock0: assert property (
        do_open && psel == `SMR_P_RAW_ETHER_MODE && idx_ff != 3'h0
        |=> state_ff == `SMR_ST_CLOSED) else $error("raw Ethernet not 0");
    a_raw_ether_mode_open: assert property (
        do_open && psel == `SMR_P_RAW_ETHER_MODE && idx_ff == 3'h0
        |=> state_ff == `SMR_ST_RAW_ETHER_MODE) else $error("raw Ethernet failed");
    a_raw_ether_mode_pad: assert property (
        TX_VALID && TX_DESC.mode == `SMR_P_RAW_ETHER_MODE
        && TX_DESC.kind == smr_pkg::SMR_TX_DATA
        |-> TX_DESC.pad_len >= `SMR_MIN_FRAME) else $error("frame short");
    a_rx_hw_path: assert property (
        RX_HDR_VALID && RX_HDR.proto == `SMR_PR_ICMP |=> RX_TO_HW)
        else $error("ping not to hardware");
    a_rawip_filter: assert property (
        RX_HDR_VALID && state_ff == `SMR_ST_RAW_IP_MODE && RX_HDR.proto != proto_ff
        |=> RX_DROP && !RX_ACCEPT) else $error("raw IP took wrong protocol");
    a_rx_frag_drop: assert property (
        RX_HDR_VALID && RX_HDR.frag && state_ff == `SMR_ST_RAW_IP_MODE
        |=> !RX_ACCEPT) else $error("fragment delivered");
    c_join_sent: cover property (
        TX_VALID && TX_READY && TX_DESC.kind == smr_pkg::SMR_TX_JOIN);
    c_send_ok: cover property ($rose(ev_ff[`SMR_EV_SENDOK]));
    c_raw_accept: cover property (RX_ACCEPT && state_ff == `SMR_ST_RAW_IP_MODE);
    c_report: cover property (
        TX_VALID && TX_DESC.kind == smr_pkg::SMR_TX_REPORT);
endmodule : smr_socket_top

/* verification/smr_eng_model.sv */
`timescale 1ns/100ps
module smr_eng_model (
    // Request side.
    input  wire logic                  clk,
    input  wire logic                  valid,
    input  wire smr_pkg::smr_tx_desc_t desc,
    input  wire logic [31:0]           slow,
    // Answers.
    output logic                       ready,
    output logic                       done,
    output logic                       arp,
    // Last taken request.
    output smr_pkg::smr_tx_desc_t      last,
    output int                         cnt
);
    // Stall, take the request, then fail the lookup for data and finish.
    initial begin
        {ready, done, arp, last} = '0;
        cnt = 0;
        forever begin
            @(posedge clk);
            #1;
            if (valid === 1'b1) begin
                repeat (slow) @(posedge clk);
                #1 ready = 1'b1;
                @(posedge clk);
                last = desc;
                #1 ready = 1'b0;
                arp = (last.kind == smr_pkg::SMR_TX_DATA);
                @(posedge clk);
                #1 arp = 1'b0;
                done = 1'b1;
                @(posedge clk);
                #1 done = 1'b0;
                cnt++;
            end
        end
    end
endmodule : smr_eng_model

/* verification/socket_multicast_rawmodes_tb.sv */
`timescale 1ns/100ps
`include "smr_consts.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin num_errors++; \
 $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module socket_multicast_rawmodes_tb;
    logic                  clk, rstn, wr, rd, hv, ok, drop, hw;
    logic                  tv, rdy, dn, arp;
    logic [7:0]            addr;
    logic [31:0]           wd, rdata;
    logic [15:0]           free;
    smr_pkg::smr_rx_hdr_t  hdr;
    smr_pkg::smr_rx_info_t info;
    smr_pkg::smr_tx_desc_t desc, last;
    int                    num_errors, compares, cnt, slow;
    smr_socket_top #(.REPORT_CYCLES(32'h40)) dut (.CORE_CLK(clk),
        .RESETN(rstn), .REG_ADDR(addr), .REG_WDATA(wd), .REG_WR(wr),
        .REG_RD(rd), .REG_RDATA(rdata), .TX_DESC(desc), .TX_VALID(tv),
        .TX_READY(rdy), .TX_DONE(dn), .ARP_TIMEOUT(arp), .RX_HDR(hdr),
        .RX_HDR_VALID(hv), .RX_FREE(free), .RX_ACCEPT(ok), .RX_DROP(drop),
        .RX_TO_HW(hw), .RX_INFO(info));
    smr_eng_model eng (.clk(clk), .valid(tv), .desc(desc), .slow(slow),
        .ready(rdy), .done(dn), .arp(arp), .last(last), .cnt(cnt));
    // The clock toggles every half period.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic results;
        $display("errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {addr, wd, wr} <= {a, d, 1'b1};
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg
    task automatic chkreg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        {addr, rd} <= {a, 1'b1};
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        `CHK(rdata, e)
    endtask : chkreg
    task automatic waittx(input smr_pkg::smr_tx_kind_t k);
        int c0;
        c0 = cnt;
        repeat (200) if (cnt == c0) @(posedge clk);
        if (cnt == c0) begin
            num_errors++;
            results();
        end
        `CHK(last.kind, k)
    endtask : waittx
    task automatic rx(input logic [7:0] p, input logic f,
                      input logic [15:0] n, input logic [2:0] e);
        @(posedge clk);
        hdr <= '{p, f, 32'hC0A80005, 16'h0BB8, n};
        hv <= 1'b1;
        @(posedge clk);
        hv <= 1'b0;
        @(negedge clk);
        `CHK({ok, drop, hw}, e)
    endtask : rx
    task automatic mcast;
        chkreg(`SMR_A_IGMPV, 32'h2);
        chkreg(`SMR_A_TX_FSR, 32'h800);
        chkreg(8'hFC, 32'h0);
        wreg(`SMR_A_DHAR_HI, 32'h100);
        wreg(`SMR_A_DHAR_LO, 32'h5E01010B);
        wreg(`SMR_A_DIPR, 32'hEF01010B);
        wreg(`SMR_A_PORT, 32'hBB8);
        wreg(`SMR_A_DPORT, 32'hBB8);
        wreg(`SMR_A_MODE, 32'h82);
        wreg(`SMR_A_CMD, 32'h1);
        waittx(smr_pkg::SMR_TX_JOIN);
        chkreg(`SMR_A_STATE, 32'h22);
        slow = 3;
        wreg(`SMR_A_TX_WR, 32'h10);
        wreg(`SMR_A_CMD, 32'h20);
        waittx(smr_pkg::SMR_TX_DATA);
        `CHK(last.dst_ip, 32'hEF01010B)
        chkreg(`SMR_A_EVENT, 32'h1);
        waittx(smr_pkg::SMR_TX_REPORT);
        wreg(`SMR_A_CMD, 32'h10);
        waittx(smr_pkg::SMR_TX_LEAVE);
    endtask : mcast
    task automatic rawip;
        wreg(`SMR_A_MODE, 32'h3);
        wreg(`SMR_A_PROTO, 32'h6);
        wreg(`SMR_A_CMD, 32'h1);
        chkreg(`SMR_A_STATE, 32'h0);
        wreg(`SMR_A_PROTO, 32'h11);
        wreg(`SMR_A_CMD, 32'h1);
        chkreg(`SMR_A_STATE, 32'h0);
        wreg(`SMR_A_PROTO, 32'h2F);
        wreg(`SMR_A_CMD, 32'h1);
        chkreg(`SMR_A_STATE, 32'h32);
        rx(8'h2F, 1'b0, 16'hFA, 3'b100);
        `CHK(info, {32'hC0A80005, 16'hFA})
        rx(8'h2F, 1'b0, 16'hFB, 3'b010);
        rx(8'h2F, 1'b1, 16'h10, 3'b010);
        rx(8'h11, 1'b0, 16'h10, 3'b010);
        rx(8'h01, 1'b0, 16'h10, 3'b011);
        rx(8'h02, 1'b0, 16'h10, 3'b011);
        // A raw send whose lookup fails sets only the timeout event.
        wreg(`SMR_A_EVENT, 32'h3);
        wreg(`SMR_A_TX_WR, 32'h30);
        wreg(`SMR_A_CMD, 32'h20);
        waittx(smr_pkg::SMR_TX_DATA);
        chkreg(`SMR_A_EVENT, 32'h2);
        wreg(`SMR_A_CMD, 32'h10);
    endtask : rawip
    task automatic rawmac;
        wreg(`SMR_A_IDX, 32'h1);
        wreg(`SMR_A_MODE, 32'h4);
        wreg(`SMR_A_CMD, 32'h1);
        chkreg(`SMR_A_STATE, 32'h0);
        wreg(`SMR_A_IDX, 32'h0);
        wreg(`SMR_A_CMD, 32'h1);
        chkreg(`SMR_A_STATE, 32'h42);
        slow = 0;
        wreg(`SMR_A_TX_WR, 32'h40);
        wreg(`SMR_A_CMD, 32'h20);
        waittx(smr_pkg::SMR_TX_DATA);
        `CHK(last.pad_len, 16'h3C)
    endtask : rawmac
    // Reset is held eight cycles, then the scenarios run in turn.
    initial begin
        {rstn, wr, rd, hv, addr, wd, hdr} = '0;
        free = 16'h100;
        slow = 0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        mcast();
        rawip();
        rawmac();
        results();
    end
endmodule : socket_multicast_rawmodes_tb
